// ---- core/rx_port_irq_enable_low.sv ----
// What this block does
// - enable bit 2 lets a forward-link parity error raise the interrupt
// - parity errors always set the first status parity flag
// - enable bit 1 lets each port-valid change raise the interrupt
// - enable bit 0 lets each lock change interrupt; first status records it
// - enable bit 4 lets a receive buffer overflow interrupt; second status
// - enable bits 0 to 6 read and write, bit 7 always reads zero; all reset to zero
// - enable bit 6 line-length change, bit 5 line-count change
//
// The implementer's own choices: the placing of the registers and the Avalon-MM interface to the registers.
`timescale 1ns/100ps
`default_nettype none

module rx_port_irq_enable_low (
  input wire logic CLK,
  input wire logic RESET,
  input wire logic [7:0] ADDRESS,
  input wire logic READ,
  input wire logic WRITE,
  input wire logic [31:0] WRITEDATA,
  input wire logic [3:0] BYTEENABLE,
  output logic [31:0] READDATA,
  output logic WAITREQUEST,
  output logic IRQ,
  input wire logic LOCKED,
  input wire logic PORT_VALID,
  input wire logic PARITY_ERR,
  input wire logic BUF_OVERFLOW,
  input wire logic LINE_LEN_CHG,
  input wire logic LINE_CNT_CHG
);

  // ----------------------------------------------------------------
  // event detection
  // ----------------------------------------------------------------
  logic lock_prev_q, lock_prev_d;
  logic valid_prev_q, valid_prev_d;
  logic primed_q, primed_d;
  logic [rx_irq_pkg::EV_W-1:0] ev;

  // primed blocks a false change on the first cycle after reset
  always_comb
  begin
    lock_prev_d = LOCKED;
    valid_prev_d = PORT_VALID;
    primed_d = 1'b1;
    ev = '0;
    ev[rx_irq_pkg::LOCK_BIT] = primed_q & (LOCKED ^ lock_prev_q);
    ev[rx_irq_pkg::VALID_BIT] = primed_q & (PORT_VALID ^ valid_prev_q);
    ev[rx_irq_pkg::PARITY_BIT] = PARITY_ERR;
    ev[rx_irq_pkg::OVERFLOW_BIT] = BUF_OVERFLOW;
    ev[rx_irq_pkg::LINE_CNT_BIT] = LINE_CNT_CHG;
    ev[rx_irq_pkg::LINE_LEN_BIT] = LINE_LEN_CHG;
  end

  always_ff @(posedge CLK)
  begin
    if (RESET)
    begin
      lock_prev_q <= 1'b0;
      valid_prev_q <= 1'b0;
      primed_q <= 1'b0;
    end
    else
    begin
      lock_prev_q <= lock_prev_d;
      valid_prev_q <= valid_prev_d;
      primed_q <= primed_d;
    end
  end

  // ----------------------------------------------------------------
  // bus slave: one wait cycle, then completion
  // ----------------------------------------------------------------
  logic wait_q, wait_d;
  logic [31:0] rdata_q, rdata_d;
  logic [7:0] en_q, en_d;
  logic req, take;
  logic [7:0] addr_w;
  logic [1:0] sts1_q, sts1_clr;
  logic [2:0] sts2_q, sts2_clr;
  logic [rx_irq_pkg::EV_W-1:0] istat_q, istat_clr;
  logic [31:0] rd_val;

  assign req = READ | WRITE;
  assign take = req & ~wait_q;
  assign addr_w = {ADDRESS[7:2], 2'b00};

  // read value decode; unmapped words read as zero
  always_comb
  begin
    rd_val = rx_irq_pkg::RD_ZERO;
    unique case (addr_w)
      rx_irq_pkg::CTL_OFS:
        rd_val[7:0] = en_q;
      rx_irq_pkg::STS_FIRST_OFS:
      begin
        rd_val[rx_irq_pkg::S1_LOCK_CHG] = sts1_q[0];
        rd_val[rx_irq_pkg::S1_PORT_VALID] = PORT_VALID;
        rd_val[rx_irq_pkg::S1_PARITY] = sts1_q[1];
        rd_val[rx_irq_pkg::S1_LOCKED] = LOCKED;
      end
      rx_irq_pkg::STS_SECOND_OFS:
        rd_val[2:0] = sts2_q;
      rx_irq_pkg::IRQ_STAT_OFS:
        rd_val[rx_irq_pkg::EV_W-1:0] = istat_q;
      default:
        rd_val = rx_irq_pkg::RD_ZERO;
    endcase
  end

  // read data is latched in the wait cycle; the clear only drops bits
  // that were latched, so an event landing in between survives
  always_comb
  begin
    wait_d = ~(req & wait_q);
    rdata_d = rdata_q;
    en_d = en_q;
    sts1_clr = '0;
    sts2_clr = '0;
    istat_clr = '0;
    if (req & wait_q & READ)
      rdata_d = rd_val;
    if (take & WRITE & BYTEENABLE[0] & (addr_w == rx_irq_pkg::CTL_OFS))
      en_d = WRITEDATA[7:0] & rx_irq_pkg::CTL_WRITABLE;
    if (take & READ)
    begin
      if (addr_w == rx_irq_pkg::STS_FIRST_OFS)
        sts1_clr = {rdata_q[rx_irq_pkg::S1_PARITY],
                    rdata_q[rx_irq_pkg::S1_LOCK_CHG]};
      if (addr_w == rx_irq_pkg::STS_SECOND_OFS)
        sts2_clr = rdata_q[2:0];
      if (addr_w == rx_irq_pkg::IRQ_STAT_OFS)
        istat_clr = rdata_q[rx_irq_pkg::EV_W-1:0];
    end
  end

  always_ff @(posedge CLK)
  begin
    if (RESET)
    begin
      wait_q <= 1'b1;
      rdata_q <= rx_irq_pkg::RD_ZERO;
      en_q <= rx_irq_pkg::CTL_RESET;
    end
    else
    begin
      wait_q <= wait_d;
      rdata_q <= rdata_d;
      en_q <= en_d;
    end
  end

  assign WAITREQUEST = wait_q;
  assign READDATA = rdata_q;

  // ----------------------------------------------------------------
  // sticky status, always updated whatever the enables say
  // ----------------------------------------------------------------
  rx_irq_flags #(.W(2)) u_sts1 (
    .CLK(CLK),
    .RESET(RESET),
    .set_i({ev[rx_irq_pkg::PARITY_BIT], ev[rx_irq_pkg::LOCK_BIT]}),
    .clr_i(sts1_clr),
    .q_o(sts1_q)
  );

  rx_irq_flags #(.W(3)) u_sts2 (
    .CLK(CLK),
    .RESET(RESET),
    .set_i({ev[rx_irq_pkg::LINE_LEN_BIT], ev[rx_irq_pkg::LINE_CNT_BIT],
            ev[rx_irq_pkg::OVERFLOW_BIT]}),
    .clr_i(sts2_clr),
    .q_o(sts2_q)
  );

  rx_irq_flags #(.W(rx_irq_pkg::EV_W)) u_istat (
    .CLK(CLK),
    .RESET(RESET),
    .set_i(ev),
    .clr_i(istat_clr),
    .q_o(istat_q)
  );

  // ----------------------------------------------------------------
  // interrupt output
  // ----------------------------------------------------------------
  logic irq_q, irq_d;

  // reserved bit 3 has no event behind it, so it can never fire
  always_comb
  begin
    irq_d = |(istat_q & en_q[rx_irq_pkg::EV_W-1:0]);
  end

  always_ff @(posedge CLK)
  begin
    if (RESET)
      irq_q <= 1'b0;
    else
      irq_q <= irq_d;
  end

  assign IRQ = irq_q;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RESET);

  sequence s_ctl_write;
    take && WRITE && BYTEENABLE[0] && (addr_w == rx_irq_pkg::CTL_OFS);
  endsequence

  sequence s_flag_up(logic f);
    ##1 f;
  endsequence

  parity_irq_a: assert property (
    PARITY_ERR && en_q[2] |-> s_flag_up(istat_q[2]) ##1 IRQ)
    else $error("parity error did not raise interrupt");
  parity_flag_a: assert property (
    PARITY_ERR |=> sts1_q[1])
    else $error("parity flag not set");
  valid_change_a: assert property (
    primed_q && $changed(PORT_VALID) |=> istat_q[1])
    else $error("port valid change missed");
  lock_change_a: assert property (
    primed_q && $changed(LOCKED) |=> sts1_q[0] && istat_q[0])
    else $error("lock change missed");
  overflow_flag_a: assert property (
    BUF_OVERFLOW |=> sts2_q[0] && istat_q[4])
    else $error("overflow not recorded");
  enable_write_a: assert property (
    s_ctl_write |=> en_q == ($past(WRITEDATA[7:0]) & 8'h7F))
    else $error("enable write not stored");
  reserved_quiet_a: assert property (
    istat_q[3] == 1'b0 && en_q[7] == 1'b0)
    else $error("reserved bit became active");
  line_change_a: assert property (
    LINE_LEN_CHG || LINE_CNT_CHG |=>
      (istat_q[6] || !$past(LINE_LEN_CHG)) &&
      (istat_q[5] || !$past(LINE_CNT_CHG)))
    else $error("line change missed");
  masked_quiet_a: assert property (
    (istat_q & en_q[6:0]) == 7'h00 |=> !IRQ)
    else $error("masked event drove interrupt");

endmodule : rx_port_irq_enable_low

`default_nettype wire

// ---- pkg/rx_irq_pkg.sv ----
`default_nettype none

package rx_irq_pkg;

  // ----------------------------------------------------------------
  // register byte offsets on the 32-bit bus
  // ----------------------------------------------------------------
  localparam logic [7:0] CTL_OFS = 8'h00;
  localparam logic [7:0] STS_FIRST_OFS = 8'h04;
  localparam logic [7:0] STS_SECOND_OFS = 8'h08;
  localparam logic [7:0] IRQ_STAT_OFS = 8'h0C;

  // ----------------------------------------------------------------
  // enable register and interrupt status layout (shared)
  // ----------------------------------------------------------------
  localparam int LOCK_BIT = 0;
  localparam int VALID_BIT = 1;
  localparam int PARITY_BIT = 2;
  localparam int RSVD_BIT = 3;
  localparam int OVERFLOW_BIT = 4;
  localparam int LINE_CNT_BIT = 5;
  localparam int LINE_LEN_BIT = 6;
  localparam int EV_W = 7;
  localparam logic [7:0] CTL_RESET = 8'h00;
  localparam logic [7:0] CTL_WRITABLE = 8'h7F;

  // ----------------------------------------------------------------
  // port status registers
  // ----------------------------------------------------------------
  localparam int S1_LOCK_CHG = 0;
  localparam int S1_PORT_VALID = 1;
  localparam int S1_PARITY = 2;
  localparam int S1_LOCKED = 3;
  localparam int S2_OVERFLOW = 0;
  localparam int S2_LINE_CNT = 1;
  localparam int S2_LINE_LEN = 2;
  localparam logic [31:0] RD_ZERO = 32'h0000_0000;

endpackage : rx_irq_pkg

`default_nettype wire

// ---- core/rx_irq_flags.sv ----
`timescale 1ns/100ps
`default_nettype none

// ------------------------------------------------------------------
// bank of sticky flags, set wins over clear
// ------------------------------------------------------------------
module rx_irq_flags #(
  parameter int W = 3
) (
  input wire logic CLK,
  input wire logic RESET,
  input wire logic [W-1:0] set_i,
  input wire logic [W-1:0] clr_i,
  output logic [W-1:0] q_o
);

  logic [W-1:0] flag_q;
  logic [W-1:0] flag_d;

  // a set arriving with its own clear survives, so no event is lost
  always_comb
  begin
    flag_d = (flag_q & ~clr_i) | set_i;
  end

  always_ff @(posedge CLK)
  begin
    if (RESET)
      flag_q <= '0;
    else
      flag_q <= flag_d;
  end

  assign q_o = flag_q;

endmodule : rx_irq_flags

`default_nettype wire

// ---- tb/test_rx_port_irq_enable_low.sv ----
`timescale 1ns/100ps
`default_nettype none

module test_rx_port_irq_enable_low;
  logic CLK, RESET, READ, WRITE, IRQ, WAITREQUEST;
  logic LOCKED, PORT_VALID, PARITY_ERR, BUF_OVERFLOW;
  logic LINE_LEN_CHG, LINE_CNT_CHG;
  logic [7:0] ADDRESS;
  logic [31:0] WRITEDATA, READDATA, d;
  logic [3:0] BYTEENABLE;
  int n_errors, tests_run, k;
  // event bit, status register and status bit of each source
  int ev[6] = '{0, 1, 2, 4, 5, 6};
  logic [7:0] sreg[6] = '{8'h04, 8'h04, 8'h04, 8'h08, 8'h08, 8'h08};
  int sbit[6] = '{0, 1, 2, 0, 1, 2};

  rx_port_irq_enable_low rx_port_irq_enable_low_i (.CLK(CLK),
    .RESET(RESET), .ADDRESS(ADDRESS), .READ(READ), .WRITE(WRITE),
    .WRITEDATA(WRITEDATA), .BYTEENABLE(BYTEENABLE), .READDATA(READDATA),
    .WAITREQUEST(WAITREQUEST), .IRQ(IRQ), .LOCKED(LOCKED),
    .PORT_VALID(PORT_VALID), .PARITY_ERR(PARITY_ERR),
    .BUF_OVERFLOW(BUF_OVERFLOW), .LINE_LEN_CHG(LINE_LEN_CHG),
    .LINE_CNT_CHG(LINE_CNT_CHG));

  // ----------------------------------------------------------------
  // clock and checking helpers
  // ----------------------------------------------------------------
  initial
  begin
    CLK = 1'b0;
    forever #25 CLK = ~CLK;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic finish_test;
    $display("errors %0d, comparisons %0d", n_errors, tests_run);
    if (n_errors == 0 && tests_run > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : finish_test

  // bus cycle: hold the request until waitrequest is seen low, then
  // idle one edge so no strobe is assigned twice in one time step
  task automatic acc(input logic w, input logic [7:0] a,
                     input logic [31:0] wd, output logic [31:0] q);
    int n;
    n = 0;
    ADDRESS <= a;
    WRITEDATA <= wd;
    READ <= !w;
    WRITE <= w;
    do
    begin
      @(posedge CLK);
      n++;
    end while (WAITREQUEST !== 1'b0 && n < 50);
    if (n >= 50)
      chk(1'b1, 1'b0);
    q = READDATA;
    READ <= 1'b0;
    WRITE <= 1'b0;
    @(posedge CLK);
  endtask : acc

  // raise one event: levels toggle, pulses last one cycle
  task automatic fire(input int b);
    if (b == 0) LOCKED <= !LOCKED;
    if (b == 1) PORT_VALID <= !PORT_VALID;
    PARITY_ERR <= (b == 2);
    BUF_OVERFLOW <= (b == 4);
    LINE_CNT_CHG <= (b == 5);
    LINE_LEN_CHG <= (b == 6);
    @(posedge CLK);
    {PARITY_ERR, BUF_OVERFLOW, LINE_CNT_CHG, LINE_LEN_CHG} <= 4'h0;
    repeat (3) @(posedge CLK);
  endtask : fire

  // ----------------------------------------------------------------
  // watchdog: the whole run needs well under 2000 cycles
  // ----------------------------------------------------------------
  initial
  begin
    #(5000 * 50);
    n_errors++;
    finish_test();
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial
  begin
    {READ, WRITE, LOCKED, PORT_VALID, PARITY_ERR} = 5'h00;
    {BUF_OVERFLOW, LINE_LEN_CHG, LINE_CNT_CHG} = 3'h0;
    ADDRESS = 8'h00;
    WRITEDATA = 32'h0000_0000;
    BYTEENABLE = 4'hF;
    n_errors = 0;
    tests_run = 0;
    RESET = 1'b1;
    repeat (12) @(posedge CLK);
    RESET <= 1'b0;
    @(posedge CLK);
    chk(IRQ, 1'b0);
    acc(0, rx_irq_pkg::CTL_OFS, 0, d);
    chk(d, 32'h0000_0000);
    acc(1, rx_irq_pkg::CTL_OFS, 32'h0000_00FF, d);
    acc(0, rx_irq_pkg::CTL_OFS, 0, d);
    chk(d, 32'h0000_007F);
    BYTEENABLE <= 4'h0;
    acc(1, rx_irq_pkg::CTL_OFS, 32'h0000_0000, d);
    BYTEENABLE <= 4'hF;
    acc(0, rx_irq_pkg::CTL_OFS, 0, d);
    chk(d, 32'h0000_007F);
    acc(0, 8'h10, 0, d);
    chk(d, 32'h0000_0000);
    // only the reserved bit on: every pulse must stay off the output
    acc(1, rx_irq_pkg::CTL_OFS, 32'h0000_0008, d);
    for (k = 0; k < 6; k++)
      fire(ev[k]);
    chk(IRQ, 1'b0);
    acc(0, rx_irq_pkg::IRQ_STAT_OFS, 0, d);
    chk(d, 32'h0000_0077);
    // both levels now high, both sticky flags set while disabled
    acc(0, rx_irq_pkg::STS_FIRST_OFS, 0, d);
    chk(d, 32'h0000_000F);
    // clearing these here keeps the per-source checks below honest
    acc(0, rx_irq_pkg::STS_SECOND_OFS, 0, d);
    chk(d, 32'h0000_0007);
    // each source alone with its own enable
    for (k = 0; k < 6; k++)
    begin
      acc(1, rx_irq_pkg::CTL_OFS, 32'h1 << ev[k], d);
      chk(IRQ, 1'b0);
      fire(ev[k]);
      chk(IRQ, 1'b1);
      acc(0, rx_irq_pkg::IRQ_STAT_OFS, 0, d);
      chk(d, 32'h1 << ev[k]);
      acc(0, sreg[k], 0, d);
      chk(d[sbit[k]], (k == 1) ? PORT_VALID : 1'b1);
      chk(IRQ, 1'b0);
    end
    // mid-run reset: enables, flags and interrupt all return to zero
    acc(1, rx_irq_pkg::CTL_OFS, 32'h0000_007F, d);
    fire(2);
    chk(IRQ, 1'b1);
    RESET <= 1'b1;
    repeat (2) @(posedge CLK);
    RESET <= 1'b0;
    @(posedge CLK);
    chk(IRQ, 1'b0);
    acc(0, rx_irq_pkg::CTL_OFS, 0, d);
    chk(d, 32'h0000_0000);
    acc(0, rx_irq_pkg::IRQ_STAT_OFS, 0, d);
    chk(d, 32'h0000_0000);
    finish_test();
  end
endmodule : test_rx_port_irq_enable_low

`default_nettype wire
